// file: hdl/epc_top.sv
`timescale 1ns/1ps
`default_nettype none
module epc_top (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [47:0] irq_line,
  input  wire logic        mem_fault,
  input  wire logic        bus_fault_precise,
  input  wire logic        bus_fault_imprecise,
  input  wire logic        usage_fault,
  input  wire logic        svc_call,
  input  wire logic        debug_req,
  input  wire logic        halting,
  input  wire logic        tick_expire,
  input  wire logic        first_instr,
  input  wire logic        core_ready,
  input  wire logic        exc_return,
  output logic             exc_take,
  output logic      [5:0]  exc_num,
  output logic             stack_push,
  output logic             vector_fetch,
  output logic             tail_chain,
  output logic             stack_pop,
  output logic             handler_mode
);
  epc_pkg::epc_state_t state;
  logic [47:0] irq_sync;
  logic [47:0] line_en;
  logic [2:0]  line_prio [epc_pkg::NLINE];
  logic [2:0]  sys_prio  [epc_pkg::NSYS];
  logic [3:0]  hen;
  logic [1:0]  sub_bits;
  logic [63:0] pend;
  logic [63:0] act;
  logic [3:0]  key_full [epc_pkg::NPOS];
  logic [3:0]  key_pre  [epc_pkg::NPOS];
  logic [63:0] elig;
  logic [2:0]  pre_mask;
  logic [3:0]  run_key;
  logic [3:0]  rest_key;
  logic [5:0]  top_pos;
  logic [5:0]  best;
  logic        cand_any;
  logic        take;
  logic        chain;
  logic        ret;
  logic        wr_ctrl;

  epc_sync #(.W(epc_pkg::NLINE)) u_irq_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       (irq_line),
    .q       (irq_sync)
  );

  assign wr_ctrl  = reg_wr && (reg_addr == epc_pkg::OFS_CTRL);
  // Group bits are the upper bits; subpriority bits are masked out
  assign pre_mask = 3'h7 << sub_bits; // R22

  // Ranking keys for every position
  always_comb begin
    logic [2:0] pr;
    logic       fixed;
    logic [3:0] fk;
    pr    = 3'h0;
    fixed = 1'b1;
    fk    = epc_pkg::KEY_BASE;
    for (int p = 0; p < epc_pkg::NPOS; p++) begin
      pr    = 3'h0;
      fixed = 1'b1;
      fk    = epc_pkg::KEY_BASE;
      case (p)
        1:       fk = epc_pkg::KEY_RESET; // R5
        2:       fk = epc_pkg::KEY_NMI; // R6
        3:       fk = epc_pkg::KEY_HARD; // R8
        4: begin
          fixed = 1'b0;
          pr    = sys_prio[epc_pkg::SYS_MEM]; // R9
        end
        5: begin
          fixed = 1'b0;
          pr    = sys_prio[epc_pkg::SYS_BUS]; // R10
        end
        6: begin
          fixed = 1'b0;
          pr    = sys_prio[epc_pkg::SYS_USAGE]; // R11
        end
        11: begin
          fixed = 1'b0;
          pr    = sys_prio[epc_pkg::SYS_SVC]; // R12
        end
        12: begin
          fixed = 1'b0;
          pr    = sys_prio[epc_pkg::SYS_DEBUG]; // R13
        end
        14: begin
          fixed = 1'b0;
          pr    = sys_prio[epc_pkg::SYS_PENDABLE_SERVICE_REQUEST]; // R14
        end
        15: begin
          fixed = 1'b0;
          pr    = sys_prio[epc_pkg::SYS_TICK]; // R15
        end
        default: begin
          if (p >= 16) begin
            fixed = 1'b0;
            pr    = line_prio[p-16]; // R16
          end
        end
      endcase
      // Settable zero lands just below hard fault
      key_full[p] = fixed ? fk : epc_pkg::KEY_SET0 + {1'b0, pr}; // R2 R24
      key_pre[p]  = fixed ? fk : epc_pkg::KEY_SET0 + {1'b0, pr & pre_mask};
    end
  end

  // Positions that may compete once pending
  always_comb begin
    elig                    = 64'h0;
    elig[epc_pkg::POS_NMI]  = 1'b1;
    elig[epc_pkg::POS_HARD] = 1'b1;
    elig[epc_pkg::POS_MEM]  = hen[epc_pkg::HCTRL_MEM_EN];
    elig[epc_pkg::POS_BUS]  = hen[epc_pkg::HCTRL_BUS_EN]; // R10
    elig[epc_pkg::POS_USAGE]  = hen[epc_pkg::HCTRL_USE_EN];
    elig[epc_pkg::POS_SVC]    = 1'b1;
    elig[epc_pkg::POS_DEBUG]  = hen[epc_pkg::HCTRL_DBG_EN] && !halting; // R13
    elig[epc_pkg::POS_PENDABLE_SERVICE_REQUEST] = 1'b1;
    elig[epc_pkg::POS_TICK]   = 1'b1;
    elig[63:16] = line_en & epc_pkg::LINE_IMPL; // R23 R18
  end

  // Running level, the newest activation and the level beneath it
  always_comb begin
    run_key  = (state == epc_pkg::ST_RESET) ? epc_pkg::KEY_RESET : epc_pkg::KEY_BASE;
    top_pos  = 6'h00;
    rest_key = epc_pkg::KEY_BASE;
    for (int p = 0; p < epc_pkg::NPOS; p++) begin
      if (act[p] && key_pre[p] < run_key) begin
        run_key = key_pre[p];
        top_pos = 6'(p);
      end
    end
    for (int p = 0; p < epc_pkg::NPOS; p++) begin
      if (act[p] && (6'(p) != top_pos) && key_pre[p] < rest_key) begin
        rest_key = key_pre[p];
      end
    end
  end

  // Strict compare in ascending order keeps the lowest position on a tie
  always_comb begin
    best     = 6'h00;
    cand_any = 1'b0;
    for (int p = 0; p < epc_pkg::NPOS; p++) begin
      if (pend[p] && elig[p] && (!cand_any || key_full[p] < key_full[best])) begin // R4
        best     = 6'(p);
        cand_any = 1'b1;
      end
    end
  end

  assign ret   = exc_return && (state == epc_pkg::ST_RUN) && (|act);
  // Only the group part decides preemption
  assign take  = cand_any && !ret && core_ready && (key_pre[best] < run_key); // R22
  assign chain = cand_any && ret && (key_pre[best] < rest_key); // R20

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= epc_pkg::ST_RESET;
    end else if (state == epc_pkg::ST_RESET && first_instr) begin
      state <= epc_pkg::ST_RUN; // R5
    end
  end

  // Register writes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_en  <= epc_pkg::EN_RST;
      hen      <= epc_pkg::HEN_RST;
      sub_bits <= epc_pkg::SUB_RST;
      for (int i = 0; i < epc_pkg::NLINE; i++) begin
        line_prio[i] <= epc_pkg::PRIO_RST; // R3
      end
      for (int i = 0; i < epc_pkg::NSYS; i++) begin
        sys_prio[i] <= epc_pkg::PRIO_RST; // R3
      end
    end else if (reg_wr) begin
      case (reg_addr)
        epc_pkg::OFS_ENSET_LO: line_en[31:0]  <= line_en[31:0] | reg_wdata; // R23
        epc_pkg::OFS_ENSET_HI: line_en[47:32] <= line_en[47:32] | reg_wdata[15:0];
        epc_pkg::OFS_ENCLR_LO: line_en[31:0]  <= line_en[31:0] & ~reg_wdata;
        epc_pkg::OFS_ENCLR_HI: line_en[47:32] <= line_en[47:32] & ~reg_wdata[15:0];
        epc_pkg::OFS_HCTRL: begin
          hen      <= reg_wdata[3:0];
          sub_bits <= reg_wdata[epc_pkg::HCTRL_SUB_LSB +: 2];
        end
        epc_pkg::OFS_SYSPRI: begin
          for (int i = 0; i < epc_pkg::NSYS; i++) begin
            sys_prio[i] <= reg_wdata[i*epc_pkg::PRI_FIELD_W +: 3]; // R23
          end
        end
        default: begin
          for (int w = 0; w < epc_pkg::NPRI_WORDS; w++) begin
            if (reg_addr == epc_pkg::OFS_LINEPRI + 8'(4*w)) begin
              for (int i = 0; i < epc_pkg::PRI_PER_WORD; i++) begin
                line_prio[w*8+i] <= reg_wdata[i*epc_pkg::PRI_FIELD_W +: 3]; // R1
              end
            end
          end
        end
      endcase
    end
  end

  // Pending flags: clears first, so a same-cycle set wins
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend <= 64'h0;
    end else begin
      if (take || chain) begin
        pend[best] <= 1'b0;
      end
      if (wr_ctrl && reg_wdata[epc_pkg::CTRL_PSV_CLR]) begin
        pend[epc_pkg::POS_PENDABLE_SERVICE_REQUEST] <= 1'b0;
      end
      if (wr_ctrl && reg_wdata[epc_pkg::CTRL_NMI_SET]) begin
        pend[epc_pkg::POS_NMI] <= 1'b1; // R7
      end
      if (wr_ctrl && reg_wdata[epc_pkg::CTRL_PSV_SET]) begin
        pend[epc_pkg::POS_PENDABLE_SERVICE_REQUEST] <= 1'b1; // R14
      end
      // A synchronous fault that cannot run now escalates
      if (mem_fault) begin
        if (elig[epc_pkg::POS_MEM] && key_pre[epc_pkg::POS_MEM] < run_key) begin
          pend[epc_pkg::POS_MEM] <= 1'b1; // R9
        end else begin
          pend[epc_pkg::POS_HARD] <= 1'b1; // R8
        end
      end
      if (bus_fault_precise) begin
        if (elig[epc_pkg::POS_BUS] && key_pre[epc_pkg::POS_BUS] < run_key) begin
          pend[epc_pkg::POS_BUS] <= 1'b1; // R10
        end else begin
          pend[epc_pkg::POS_HARD] <= 1'b1; // R8
        end
      end
      // Imprecise faults wait for their level unless disabled
      if (bus_fault_imprecise) begin
        if (elig[epc_pkg::POS_BUS]) begin
          pend[epc_pkg::POS_BUS] <= 1'b1; // R10
        end else begin
          pend[epc_pkg::POS_HARD] <= 1'b1; // R8
        end
      end
      if (usage_fault) begin
        if (elig[epc_pkg::POS_USAGE] && key_pre[epc_pkg::POS_USAGE] < run_key) begin
          pend[epc_pkg::POS_USAGE] <= 1'b1; // R11
        end else begin
          pend[epc_pkg::POS_HARD] <= 1'b1; // R8
        end
      end
      if (svc_call) begin
        pend[epc_pkg::POS_SVC] <= 1'b1; // R12
      end
      if (debug_req && elig[epc_pkg::POS_DEBUG]) begin
        pend[epc_pkg::POS_DEBUG] <= 1'b1; // R13
      end
      if (tick_expire) begin
        pend[epc_pkg::POS_TICK] <= 1'b1; // R15
      end
      // Level lines re-pend only after their handler has left; the entry edge
      // still sees the old activation set, so it is excluded explicitly
      for (int i = 0; i < epc_pkg::NLINE; i++) begin
        if (irq_sync[i] && epc_pkg::LINE_IMPL[i] && !act[16+i] &&
            !((take || chain) && best == 6'(16+i))) begin
          pend[16+i] <= 1'b1; // R16 R17 R18
        end
      end
    end
  end

  // Activation set; nesting depth follows group priority
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act <= 64'h0;
    end else begin
      if (ret) begin
        act[top_pos] <= 1'b0;
      end
      if (take || chain) begin
        act[best] <= 1'b1;
      end
    end
  end

  // Core handshake outputs
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exc_take     <= 1'b0;
      exc_num      <= 6'h00;
      stack_push   <= 1'b0;
      vector_fetch <= 1'b0;
      tail_chain   <= 1'b0;
      stack_pop    <= 1'b0;
      handler_mode <= 1'b0;
    end else begin
      exc_take     <= take || chain;
      stack_push   <= take; // R19
      vector_fetch <= take || chain; // R19
      tail_chain   <= chain; // R20
      stack_pop    <= ret && !chain; // R19
      handler_mode <= |act; // R21
      if (take || chain) begin
        exc_num <= best;
      end
    end
  end

  // Read port; unmapped offsets read zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0;
      case (reg_addr)
        epc_pkg::OFS_CTRL: begin
          reg_rdata[5:0] <= top_pos;
          reg_rdata[epc_pkg::CTRL_PEND_LSB +: 6] <= best;
          reg_rdata[epc_pkg::CTRL_NMI_SET] <= pend[epc_pkg::POS_NMI];
          reg_rdata[epc_pkg::CTRL_PSV_SET] <= pend[epc_pkg::POS_PENDABLE_SERVICE_REQUEST];
        end
        epc_pkg::OFS_ENSET_LO, epc_pkg::OFS_ENCLR_LO: reg_rdata <= line_en[31:0];
        epc_pkg::OFS_ENSET_HI, epc_pkg::OFS_ENCLR_HI: reg_rdata[15:0] <= line_en[47:32];
        epc_pkg::OFS_HCTRL: begin
          reg_rdata[3:0] <= hen;
          reg_rdata[epc_pkg::HCTRL_SUB_LSB +: 2] <= sub_bits;
        end
        epc_pkg::OFS_SYSPRI: begin
          for (int i = 0; i < epc_pkg::NSYS; i++) begin
            reg_rdata[i*epc_pkg::PRI_FIELD_W +: 3] <= sys_prio[i];
          end
        end
        epc_pkg::OFS_PEND_LO: reg_rdata <= pend[47:16];
        epc_pkg::OFS_PEND_HI: reg_rdata[15:0] <= pend[63:48];
        default: begin
          for (int w = 0; w < epc_pkg::NPRI_WORDS; w++) begin
            if (reg_addr == epc_pkg::OFS_LINEPRI + 8'(4*w)) begin
              for (int i = 0; i < epc_pkg::PRI_PER_WORD; i++) begin
                reg_rdata[i*epc_pkg::PRI_FIELD_W +: 3] <= line_prio[w*8+i];
              end
            end
          end
        end
      endcase
    end
  end

  chk_nmi_soft: assert property (@(posedge ref_clk) disable iff (sys_rst) // R7
    $rose(pend[2]) |-> $past(wr_ctrl && reg_wdata[31]))
    else $error("non-maskable pended without a control write");
  chk_hard_escalate: assert property (@(posedge ref_clk) disable iff (sys_rst) // R8
    (mem_fault && !hen[0]) |=> pend[3])
    else $error("disabled memory fault did not escalate");
  chk_entry_push: assert property (@(posedge ref_clk) disable iff (sys_rst) // R19
    exc_take |-> vector_fetch && (stack_push != tail_chain))
    else $error("entry without fetch or with both push and chain");
  chk_chain_no_pop: assert property (@(posedge ref_clk) disable iff (sys_rst) // R20
    (ret && chain) |=> tail_chain && !stack_pop && exc_take)
    else $error("tail chain did not skip the pop");
  chk_handler_mode: assert property (@(posedge ref_clk) disable iff (sys_rst) // R21
    exc_take |=> handler_mode)
    else $error("handler not in handler mode");
  chk_reserved_pos: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
    pend[10:7] == 4'h0 && !pend[13] && !pend[0] && !pend[1])
    else $error("reserved position pended");
  chk_reserved_line: assert property (@(posedge ref_clk) disable iff (sys_rst) // R18
    (pend[63:16] & ~epc_pkg::LINE_IMPL) == 48'h0)
    else $error("reserved line pended");
  chk_reset_block: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
    (state == epc_pkg::ST_RESET) |=> !exc_take)
    else $error("exception taken before first instruction");
  chk_first_drop: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
    (state == epc_pkg::ST_RESET && first_instr) |=> state == epc_pkg::ST_RUN)
    else $error("reset level not dropped");
  chk_prio_reset: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
    $past(sys_rst) |-> line_prio[0] == 3'h0 && sys_prio[0] == 3'h0)
    else $error("priority field not zero after reset");
  chk_pendable_service_request_set: assert property (@(posedge ref_clk) disable iff (sys_rst) // R14
    (wr_ctrl && reg_wdata[28]) |=> pend[14])
    else $error("pendable request write lost");
endmodule
`default_nettype wire

// file: hdl/epc_pkg.sv
// Operation
// R1 - Eight settable levels on seven system exceptions and 26 peripheral lines.
// R2 - Settable level zero ranks fourth, below reset, non-maskable and hard fault.
// R3 - Every settable priority field resets to zero.
// R4 - Equal priority ties go to the lower exception position.
// R5 - Reset at position 1, level -3; drops to base on first instruction.
// R6 - Non-maskable at position 2, level -2; only reset outranks it.
// R7 - Non-maskable is raised only by a software control register write.
// R8 - Hard fault at position 3, level -1; takes faults that cannot activate.
// R9 - Memory management at position 4, settable, raised on protection unit mismatch.
// R10 - Bus fault at position 5, settable, software enabled; precise or imprecise.
// R11 - Usage fault at position 6, settable, on undefined instruction or bad state.
// R12 - Supervisor call at position 11; positions 7-10 and 13 reserved.
// R13 - Debug monitor at 12, only when enabled and not halting, never below current.
// R14 - Pendable service request at 14, pended only by software.
// R15 - System tick at 15, raised when the tick timer expires.
// R16 - Peripheral lines occupy positions 16 upward, synchronised and prioritised.
// R17 - Peripheral line numbering follows the fixed assignment of sources.
// R18 - Unassigned line numbers, including 44-47, are reserved.
// R19 - Entry pushes state with concurrent vector fetch; return pops state.
// R20 - Tail-chaining enters a pending exception without pop and push.
// R21 - Every handler runs in handler mode.
// R22 - Priority splits into preemption group and subpriority; only group preempts.
// R23 - Lines have set-enable bits and priority fields; system exceptions have fields.
// R24 - Settable priorities are three bits; smaller value is more urgent.
package epc_pkg;

  localparam int NLINE = 48;
  localparam int NPOS  = 64;
  localparam int NSYS  = 7;

  // Exception positions
  localparam logic [5:0] POS_RESET   = 6'h01;
  localparam logic [5:0] POS_NMI     = 6'h02;
  localparam logic [5:0] POS_HARD    = 6'h03;
  localparam logic [5:0] POS_MEM     = 6'h04;
  localparam logic [5:0] POS_BUS     = 6'h05;
  localparam logic [5:0] POS_USAGE   = 6'h06;
  localparam logic [5:0] POS_SVC     = 6'h0b;
  localparam logic [5:0] POS_DEBUG   = 6'h0c;
  localparam logic [5:0] POS_PENDABLE_SERVICE_REQUEST  = 6'h0e;
  localparam logic [5:0] POS_TICK    = 6'h0f;
  localparam logic [5:0] POS_LINE0   = 6'h10;

  // Implemented peripheral lines; all other bits are reserved
  localparam logic [47:0] LINE_IMPL  = 48'h0081_fffc_07bf;

  // Index of each system exception in the system priority register
  localparam int SYS_MEM    = 0;
  localparam int SYS_BUS    = 1;
  localparam int SYS_USAGE  = 2;
  localparam int SYS_SVC    = 3;
  localparam int SYS_DEBUG  = 4;
  localparam int SYS_PENDABLE_SERVICE_REQUEST = 5;
  localparam int SYS_TICK   = 6;

  // Ranking keys; lower is more urgent
  localparam logic [3:0] KEY_RESET   = 4'h0;
  localparam logic [3:0] KEY_NMI     = 4'h1;
  localparam logic [3:0] KEY_HARD    = 4'h2;
  localparam logic [3:0] KEY_SET0    = 4'h3;
  localparam logic [3:0] KEY_BASE    = 4'hf;

  // Register offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_ENSET_LO = 8'h04;
  localparam logic [7:0] OFS_ENSET_HI = 8'h08;
  localparam logic [7:0] OFS_ENCLR_LO = 8'h0c;
  localparam logic [7:0] OFS_ENCLR_HI = 8'h10;
  localparam logic [7:0] OFS_HCTRL    = 8'h14;
  localparam logic [7:0] OFS_SYSPRI   = 8'h18;
  localparam logic [7:0] OFS_LINEPRI  = 8'h20;
  localparam logic [7:0] OFS_PEND_LO  = 8'h38;
  localparam logic [7:0] OFS_PEND_HI  = 8'h3c;

  // Field positions
  localparam int CTRL_NMI_SET   = 31;
  localparam int CTRL_PSV_SET   = 28;
  localparam int CTRL_PSV_CLR   = 27;
  localparam int CTRL_PEND_LSB  = 16;
  localparam int HCTRL_MEM_EN   = 0;
  localparam int HCTRL_BUS_EN   = 1;
  localparam int HCTRL_USE_EN   = 2;
  localparam int HCTRL_DBG_EN   = 3;
  localparam int HCTRL_SUB_LSB  = 8;
  localparam int PRI_FIELD_W    = 4;
  localparam int PRI_PER_WORD   = 8;
  localparam int NPRI_WORDS     = 6;

  // Reset values
  localparam logic [2:0]  PRIO_RST  = 3'h0;
  localparam logic [47:0] EN_RST    = 48'h0;
  localparam logic [3:0]  HEN_RST   = 4'h0;
  localparam logic [1:0]  SUB_RST   = 2'h0;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN   = 2'b01
  } epc_state_t;

endpackage

// file: hdl/epc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module epc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // Only the second stage is visible outside
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// file: dv/epc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module epc_core_model (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic stall,
  input  wire logic ret_cmd,
  input  wire logic handler_mode,
  output logic      core_ready,
  output logic      exc_return
);
  // A return is only offered while a handler is active, as a real core would
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_ready <= 1'b0;
      exc_return <= 1'b0;
    end else begin
      core_ready <= !stall;
      exc_return <= ret_cmd && handler_mode;
    end
  end
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        ref_clk     = 1'b0;
  logic        sys_rst     = 1'b1;
  logic [7:0]  reg_addr    = 8'h00;
  logic [31:0] reg_wdata   = 32'h0;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [47:0] irq_line    = 48'h0;
  logic [6:0]  src         = 7'h00;
  logic        halting     = 1'b0;
  logic        first_instr = 1'b0;
  logic        stall       = 1'b0;
  logic        ret_cmd     = 1'b0;
  logic [31:0] reg_rdata;
  logic [5:0]  exc_num;
  logic        core_ready, exc_return, exc_take, vector_fetch;
  logic        stack_push, tail_chain, stack_pop, handler_mode;
  int          fail_count  = 0;
  int          comparisons = 0;

  always #5 ref_clk = ~ref_clk;

  epc_top u_epc_top (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_line(irq_line),
    .mem_fault(src[0]), .bus_fault_precise(src[1]), .usage_fault(src[2]),
    .svc_call(src[3]), .debug_req(src[4]), .tick_expire(src[5]),
    .bus_fault_imprecise(src[6]), .halting(halting), .first_instr(first_instr),
    .core_ready(core_ready), .exc_return(exc_return), .exc_take(exc_take),
    .exc_num(exc_num), .stack_push(stack_push), .vector_fetch(vector_fetch),
    .tail_chain(tail_chain), .stack_pop(stack_pop), .handler_mode(handler_mode)
  );

  epc_core_model u_epc_core_model (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .stall(stall), .ret_cmd(ret_cmd),
    .handler_mode(handler_mode), .core_ready(core_ready), .exc_return(exc_return)
  );

  task automatic stop_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask

  task automatic quiet(input int cyc);
    repeat (cyc) begin
      @(posedge ref_clk);
      #1 chkb("exc_take", 1'b0, exc_take);
    end
  endtask

  task automatic drop(input logic [47:0] m);
    @(posedge ref_clk);
    irq_line <= irq_line & ~m;
    quiet(4);
  endtask

  task automatic pulse(input int i);
    @(posedge ref_clk);
    src[i] <= 1'b1;
    @(posedge ref_clk);
    src <= 7'h00;
  endtask

  // A missing entry ends the run at once; later checks would only cascade
  task automatic take(input logic [5:0] num, input logic tail);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (exc_take !== 1'b1 && n < 40);
    if (exc_take !== 1'b1) begin
      fail_count++;
      $display("BAD exc_take expected 1 seen %b", exc_take);
      stop_test();
    end
    chk("exc_num", {26'h0, num}, {26'h0, exc_num});
    chkb("vector_fetch", 1'b1, vector_fetch);
    chkb("stack_push", !tail, stack_push);
    chkb("tail_chain", tail, tail_chain);
    @(posedge ref_clk);
    #1 chkb("handler_mode", 1'b1, handler_mode);
  endtask

  task automatic ret(input logic [5:0] num);
    int n;
    @(posedge ref_clk);
    ret_cmd <= 1'b1;
    @(posedge ref_clk);
    ret_cmd <= 1'b0;
    if (num != 6'h00) begin
      take(num, 1'b1);
    end else begin
      n = 0;
      do begin
        @(posedge ref_clk);
        #1 n++;
      end while (stack_pop !== 1'b1 && n < 20);
      chkb("stack_pop", 1'b1, stack_pop);
    end
  endtask

  task automatic t_start();
    rdchk(epc_pkg::OFS_SYSPRI, 32'h0, "sys_pri");
    for (int w = 0; w < 6; w++) begin
      rdchk(epc_pkg::OFS_LINEPRI + 8'(4 * w), 32'h0, "line_pri");
    end
    rdchk(epc_pkg::OFS_HCTRL, 32'h0, "hctrl");
    rdchk(8'hfc, 32'h0, "unmapped");
    wr(epc_pkg::OFS_ENSET_LO, 32'h1);
    @(posedge ref_clk);
    irq_line[0] <= 1'b1;
    quiet(10);
    @(posedge ref_clk);
    first_instr <= 1'b1;
    @(posedge ref_clk);
    first_instr <= 1'b0;
    take(6'h10, 1'b0);
    drop(48'h1);
    ret(6'h00);
  endtask

  task automatic t_nmi();
    @(posedge ref_clk);
    stall       <= 1'b1;
    irq_line[0] <= 1'b1;
    wr(epc_pkg::OFS_CTRL, 32'h8000_0000);
    quiet(5);
    @(posedge ref_clk);
    stall <= 1'b0;
    take(6'h02, 1'b0);
    quiet(4);
    ret(6'h10);
    drop(48'h1);
    ret(6'h00);
  endtask

  task automatic t_tie();
    wr(epc_pkg::OFS_LINEPRI, 32'h0000_1120);
    wr(epc_pkg::OFS_ENSET_LO, 32'h0000_000e);
    rdchk(epc_pkg::OFS_ENSET_LO, 32'h0000_000f, "enables");
    @(posedge ref_clk);
    stall         <= 1'b1;
    irq_line[3:1] <= 3'b111;
    quiet(6);
    @(posedge ref_clk);
    stall <= 1'b0;
    take(6'h12, 1'b0);
    drop(48'h4);
    ret(6'h13);
    drop(48'h8);
    ret(6'h11);
    drop(48'h2);
    ret(6'h00);
  endtask

  task automatic t_src();
    logic [5:0] nums [7];
    nums = '{6'h04, 6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0f, 6'h05};
    pulse(0);
    take(6'h03, 1'b0);
    ret(6'h00);
    wr(epc_pkg::OFS_HCTRL, 32'h0000_000f);
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      take(nums[i], 1'b0);
      ret(6'h00);
    end
    wr(epc_pkg::OFS_CTRL, 32'h1000_0000);
    take(6'h0e, 1'b0);
    ret(6'h00);
    @(posedge ref_clk);
    halting <= 1'b1;
    pulse(4);
    quiet(10);
    @(posedge ref_clk);
    halting <= 1'b0;
  endtask

  // Ends with everything held pending; the run stops here on purpose
  task automatic t_lines();
    @(posedge ref_clk);
    stall <= 1'b1;
    wr(epc_pkg::OFS_ENSET_LO, 32'hffff_ffff);
    wr(epc_pkg::OFS_ENSET_HI, 32'h0000_ffff);
    @(posedge ref_clk);
    irq_line <= 48'hffff_ffff_ffff;
    quiet(6);
    rdchk(epc_pkg::OFS_PEND_LO, 32'hfffc_07bf, "pend_lo");
    rdchk(epc_pkg::OFS_PEND_HI, 32'h0000_0081, "pend_hi");
    rdchk(epc_pkg::OFS_CTRL, 32'h0010_0000, "ctrl");
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_start();
    t_nmi();
    t_tie();
    t_src();
    t_lines();
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
